// [design/smb_top.sv]
// supply monitor control and battery-backed backup registers
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns

// Notes on behaviour
// - with the low-voltage enable at bit 16 set, a drop of the analog rail below threshold sets the low-voltage flag and its interrupt status bit.
// - the read-only brown-out flag at bit 3 is 1 while the main rail is at or below threshold.
// - the action select at bit 1 picks whole-chip reset (0) or interrupt (1) on brown-out.
// - the brown-out detector works only while its enable at bit 0 is 1.
// - ten read/write 32-bit backup words sit at word offsets 0x200 through 0x224.
// - backup words clear to zero only on a backup domain reset or a write of 1 to the domain soft reset bit.
// - backup words keep their values while the core rail is off.
// - the low-voltage flag at bit 19 gives an interrupt if irq wake is on, else an event if event wake is on.
// - the threshold select has its top bit at 22 and its low bits at 18 to 17.
// - writing 1 to the domain soft reset bit resets every backup domain register.
module smb_top
  import smb_pkg::*;
(
  // clock and backup domain reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [SMB_ADDR_W-1:0] addr_i,
  input wire logic [SMB_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SMB_DATA_W-1:0] rdata_o,
  // analog comparators and core rail status
  input wire logic lvd_below_i,
  input wire logic bod_below_i,
  input wire logic core_supply_off_i,
  // controls toward the analog monitors
  output smb_analog_t analog_o,
  // system responses
  output logic low_volt_event_o,
  output logic low_volt_irq_o,
  output logic low_volt_wake_o,
  output logic brownout_reset_o,
  output logic irq_o
);

  // ==========================================================
  // declarations
  smb_ctrl_t ctrl;
  logic [SMB_DATA_W-1:0] backup_word [SMB_BACKUP_WORDS];
  logic [SMB_IRQ_W-1:0] irq_status;
  logic [SMB_IRQ_W-1:0] irq_mask;
  logic [SMB_IRQ_W-1:0] irq_set;
  logic lvd_sync;
  logic bod_sync;
  logic core_off_sync;
  logic low_volt_flag;
  logic brownout_flag;
  logic low_volt_flag_d;
  logic brownout_flag_d;
  logic lvd_rise;
  logic bod_rise;
  logic bus_ok;
  logic wr_ok;
  logic rd_ok;
  logic soft_reset;
  logic hit_ctrl;
  logic hit_csr;
  logic hit_status;
  logic hit_mask;
  logic hit_backup;
  logic [SMB_ADDR_W-1:0] backup_ofs;
  logic [SMB_BACKUP_IDX_W-1:0] backup_idx;
  logic [SMB_DATA_W-1:0] csr_value;
  logic [SMB_DATA_W-1:0] next_rdata;

  // ==========================================================
  // input synchronisers
  smb_sync2 u_sync_lvd (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(lvd_below_i),
    .sync_o(lvd_sync)
  );

  smb_sync2 u_sync_bod (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(bod_below_i),
    .sync_o(bod_sync)
  );

  smb_sync2 u_sync_core (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(core_supply_off_i),
    .sync_o(core_off_sync)
  );

  // ==========================================================
  // address decode
  // accesses from a powered-down core are dropped
  assign bus_ok = ~core_off_sync;
  assign wr_ok = wr_i & bus_ok;
  assign rd_ok = rd_i & bus_ok;

  assign hit_ctrl = (addr_i == SMB_OFS_DOMAIN_CTRL);
  assign hit_csr = (addr_i == SMB_OFS_MON_CSR);
  assign hit_status = (addr_i == SMB_OFS_IRQ_STATUS);
  assign hit_mask = (addr_i == SMB_OFS_IRQ_MASK);

  // word aligned window of the backup words
  assign hit_backup = (addr_i >= SMB_OFS_BACKUP_FIRST)
                    && (addr_i <= SMB_OFS_BACKUP_LAST)
                    && (addr_i[1:0] == 2'h0);
  assign backup_ofs = addr_i - SMB_OFS_BACKUP_FIRST;
  assign backup_idx = backup_ofs[SMB_BACKUP_IDX_W+1:2];

  // self clearing: acts in the cycle of the write only
  assign soft_reset = wr_ok & hit_ctrl & wdata_i[SMB_BIT_SOFT_RESET];

  // ==========================================================
  // monitor control register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= SMB_RST_CTRL;
    end else if (soft_reset) begin
      ctrl <= SMB_RST_CTRL;
    end else if (wr_ok && hit_csr) begin
      ctrl.lvd_sel_hi <= wdata_i[SMB_BIT_LVD_SEL_HI];
      ctrl.low_volt_event_wake_enable <= wdata_i[SMB_BIT_LVD_EVT_WAKE];
      ctrl.low_volt_irq_wake_enable <= wdata_i[SMB_BIT_LVD_IRQ_WAKE];
      ctrl.lvd_sel_lo <= wdata_i[SMB_BIT_LVD_SEL_LO_HI:SMB_BIT_LVD_SEL_LO_LO];
      ctrl.low_volt_detect_enable <= wdata_i[SMB_BIT_LVD_EN];
      ctrl.brownout_action_select <= wdata_i[SMB_BIT_BOD_ACTION];
      ctrl.brownout_detector_enable <= wdata_i[SMB_BIT_BOD_EN];
    end
  end

  // ==========================================================
  // monitor flags
  // a disabled detector shows no condition
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_volt_flag <= SMB_RST_BIT;
      brownout_flag <= SMB_RST_BIT;
    end else if (soft_reset) begin
      low_volt_flag <= SMB_RST_BIT;
      brownout_flag <= SMB_RST_BIT;
    end else begin
      low_volt_flag <= lvd_sync & ctrl.low_volt_detect_enable;
      brownout_flag <= bod_sync & ctrl.brownout_detector_enable;
    end
  end

  // previous flags for rise detection
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_volt_flag_d <= SMB_RST_BIT;
      brownout_flag_d <= SMB_RST_BIT;
    end else begin
      low_volt_flag_d <= low_volt_flag;
      brownout_flag_d <= brownout_flag;
    end
  end

  assign lvd_rise = low_volt_flag & ~low_volt_flag_d;
  assign bod_rise = brownout_flag & ~brownout_flag_d;

  // ==========================================================
  // system responses
  // event pulse only when irq wake is off
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_volt_event_o <= SMB_RST_BIT;
    end else begin
      low_volt_event_o <= lvd_rise
                        & ctrl.low_volt_event_wake_enable
                        & ~ctrl.low_volt_irq_wake_enable;
    end
  end

  // level request toward the core interrupt controller
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_volt_irq_o <= SMB_RST_BIT;
    end else begin
      low_volt_irq_o <= low_volt_flag & ctrl.low_volt_irq_wake_enable;
    end
  end

  // regulator wake while the condition stands
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_volt_wake_o <= SMB_RST_BIT;
    end else begin
      low_volt_wake_o <= low_volt_flag & ctrl.low_volt_event_wake_enable;
    end
  end

  // whole chip reset while brown-out stands and reset action chosen
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brownout_reset_o <= SMB_RST_BIT;
    end else begin
      brownout_reset_o <= brownout_flag & ~ctrl.brownout_action_select;
    end
  end

  // analog controls follow the register one cycle later
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      analog_o <= '0;
    end else begin
      analog_o.lvd_level_sel <= {ctrl.lvd_sel_hi, ctrl.lvd_sel_lo};
      analog_o.lvd_enable <= ctrl.low_volt_detect_enable;
      analog_o.bod_enable <= ctrl.brownout_detector_enable;
    end
  end

  // ==========================================================
  // interrupt status and mask
  assign irq_set[SMB_IRQ_LVD] = lvd_rise;
  assign irq_set[SMB_IRQ_BOD] = bod_rise & ctrl.brownout_action_select;

  // write one clears; a new event wins over the clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_status <= SMB_RST_IRQ;
    end else if (soft_reset) begin
      irq_status <= SMB_RST_IRQ;
    end else if (wr_ok && hit_status) begin
      irq_status <= (irq_status & ~wdata_i[SMB_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask <= SMB_RST_IRQ;
    end else if (soft_reset) begin
      irq_mask <= SMB_RST_IRQ;
    end else if (wr_ok && hit_mask) begin
      irq_mask <= wdata_i[SMB_IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // ==========================================================
  // backup words
  // cleared only by the domain reset or its software form
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < SMB_BACKUP_WORDS; i++) begin
        backup_word[i] <= SMB_RST_WORD;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < SMB_BACKUP_WORDS; i++) begin
        backup_word[i] <= SMB_RST_WORD;
      end
    end else if (wr_ok && hit_backup) begin
      backup_word[backup_idx] <= wdata_i;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    csr_value = '0;
    csr_value[SMB_BIT_LVD_SEL_HI] = ctrl.lvd_sel_hi;
    csr_value[SMB_BIT_LVD_EVT_WAKE] = ctrl.low_volt_event_wake_enable;
    csr_value[SMB_BIT_LVD_IRQ_WAKE] = ctrl.low_volt_irq_wake_enable;
    csr_value[SMB_BIT_LVD_FLAG] = low_volt_flag;
    csr_value[SMB_BIT_LVD_SEL_LO_HI:SMB_BIT_LVD_SEL_LO_LO] = ctrl.lvd_sel_lo;
    csr_value[SMB_BIT_LVD_EN] = ctrl.low_volt_detect_enable;
    csr_value[SMB_BIT_BOD_FLAG] = brownout_flag;
    csr_value[SMB_BIT_BOD_ACTION] = ctrl.brownout_action_select;
    csr_value[SMB_BIT_BOD_EN] = ctrl.brownout_detector_enable;
  end

  // unmapped addresses and the soft reset bit read as zero
  always_comb begin
    next_rdata = '0;
    if (rd_ok) begin
      if (hit_csr) begin
        next_rdata = csr_value;
      end else if (hit_status) begin
        next_rdata[SMB_IRQ_W-1:0] = irq_status;
      end else if (hit_mask) begin
        next_rdata[SMB_IRQ_W-1:0] = irq_mask;
      end else if (hit_backup) begin
        next_rdata = backup_word[backup_idx];
      end
    end
  end

  // data stand one cycle, zero otherwise
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= SMB_RST_WORD;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : smb_top

// [include/smb_pkg.sv]
// constants and types of the supply monitor and backup register block
package smb_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned SMB_ADDR_W = 12;
  localparam int unsigned SMB_DATA_W = 32;

  // ==========================================================
  // register offsets
  localparam logic [11:0] SMB_OFS_DOMAIN_CTRL = 12'h104;
  localparam logic [11:0] SMB_OFS_MON_CSR = 12'h110;
  localparam logic [11:0] SMB_OFS_IRQ_STATUS = 12'h120;
  localparam logic [11:0] SMB_OFS_IRQ_MASK = 12'h124;
  localparam logic [11:0] SMB_OFS_BACKUP_FIRST = 12'h200;
  localparam logic [11:0] SMB_OFS_BACKUP_LAST = 12'h224;
  localparam int unsigned SMB_BACKUP_WORDS = 10;
  localparam int unsigned SMB_BACKUP_IDX_W = 4;

  // ==========================================================
  // field positions of the monitor control and status register
  localparam int unsigned SMB_BIT_LVD_SEL_HI = 22;
  localparam int unsigned SMB_BIT_LVD_EVT_WAKE = 21;
  localparam int unsigned SMB_BIT_LVD_IRQ_WAKE = 20;
  localparam int unsigned SMB_BIT_LVD_FLAG = 19;
  localparam int unsigned SMB_BIT_LVD_SEL_LO_HI = 18;
  localparam int unsigned SMB_BIT_LVD_SEL_LO_LO = 17;
  localparam int unsigned SMB_BIT_LVD_EN = 16;
  localparam int unsigned SMB_BIT_BOD_FLAG = 3;
  localparam int unsigned SMB_BIT_BOD_ACTION = 1;
  localparam int unsigned SMB_BIT_BOD_EN = 0;

  // domain control and interrupt fields
  localparam int unsigned SMB_BIT_SOFT_RESET = 0;
  localparam int unsigned SMB_IRQ_W = 2;
  localparam int unsigned SMB_IRQ_LVD = 0;
  localparam int unsigned SMB_IRQ_BOD = 1;

  // ==========================================================
  // reset values
  localparam logic [31:0] SMB_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] SMB_RST_IRQ = 2'h0;
  localparam logic SMB_RST_BIT = 1'b0;

  // ==========================================================
  // software controls of the monitors
  typedef struct packed {
    logic lvd_sel_hi;
    logic low_volt_event_wake_enable;
    logic low_volt_irq_wake_enable;
    logic [1:0] lvd_sel_lo;
    logic low_volt_detect_enable;
    logic brownout_action_select;
    logic brownout_detector_enable;
  } smb_ctrl_t;

  localparam smb_ctrl_t SMB_RST_CTRL = '0;

  // outputs toward the analog comparators
  typedef struct packed {
    logic [2:0] lvd_level_sel;
    logic lvd_enable;
    logic bod_enable;
  } smb_analog_t;

endpackage : smb_pkg

// [design/smb_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ns
module smb_sync2
  import smb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // level in and out
  input wire logic async_i,
  output logic sync_o
);

  logic stage_one;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_one <= SMB_RST_BIT;
      sync_o <= SMB_RST_BIT;
    end else begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end

endmodule : smb_sync2

// [test/smb_top_asserts.sv]
// concurrent checks on the ports of the supply monitor block
`timescale 1ns/1ns
module smb_top_asserts
  import smb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [SMB_ADDR_W-1:0] addr_i,
  input wire logic [SMB_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [SMB_DATA_W-1:0] rdata_o,
  // monitors and responses
  input wire logic lvd_below_i,
  input wire logic bod_below_i,
  input wire logic core_supply_off_i,
  input wire smb_analog_t analog_o,
  input wire logic low_volt_event_o,
  input wire logic low_volt_irq_o,
  input wire logic low_volt_wake_o,
  input wire logic brownout_reset_o,
  input wire logic irq_o
);
  // ==========================================================
  // assertions
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence bus_ok;
    (!core_supply_off_i)[*3];
  endsequence
  sequence csr_wr;
    bus_ok ##0 (wr_i && addr_i == SMB_OFS_MON_CSR);
  endsequence
  a_word_readback: assert property (
    bus_ok ##0 (wr_i && addr_i == SMB_OFS_BACKUP_FIRST) ##1 (rd_i && addr_i == SMB_OFS_BACKUP_FIRST)
    |=> rdata_o == $past(wdata_i, 2)) else $error("backup word read back wrong");
  a_unmapped_read: assert property (rd_i && addr_i == 12'h228 |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_lvd_map: assert property (csr_wr |=> ##1 analog_o.lvd_enable == $past(wdata_i[16], 2)
    && analog_o.lvd_level_sel == {$past(wdata_i[22], 2), $past(wdata_i[18:17], 2)}) else $error("lvd controls wrong");
  a_bod_map: assert property (csr_wr |=> ##1 analog_o.bod_enable == $past(wdata_i[0], 2))
    else $error("bod enable wrong");
  a_lvd_sync: assert property ((!lvd_below_i)[*4] ##1 lvd_below_i |-> (!low_volt_irq_o && !low_volt_wake_o)[*4])
    else $error("low-volt response too early");
  a_bod_sync: assert property ((!bod_below_i)[*4] ##1 bod_below_i |-> (!brownout_reset_o)[*4])
    else $error("brown-out reset too early");
  a_lvd_quiet: assert property ((!analog_o.lvd_enable)[*3] |-> !(low_volt_event_o || low_volt_irq_o || low_volt_wake_o))
    else $error("disabled lvd responded");
  a_bod_quiet: assert property ((!analog_o.bod_enable)[*3] |-> !brownout_reset_o)
    else $error("disabled bod reset");
  a_event_only: assert property (low_volt_event_o |-> !low_volt_irq_o)
    else $error("event beside interrupt");
  a_soft_clear: assert property (
    bus_ok ##0 (wr_i && addr_i == SMB_OFS_DOMAIN_CTRL && wdata_i[0]) |=> !irq_o ##1 (analog_o == '0 && !brownout_reset_o))
    else $error("soft reset left state");
  c_lvd_event: cover property (low_volt_event_o);
  c_bod_reset: cover property (brownout_reset_o);
  c_irq: cover property (irq_o);
endmodule : smb_top_asserts

bind smb_top smb_top_asserts smb_chk_u (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .lvd_below_i(lvd_below_i), .bod_below_i(bod_below_i), .core_supply_off_i(core_supply_off_i),
  .analog_o(analog_o), .low_volt_event_o(low_volt_event_o), .low_volt_irq_o(low_volt_irq_o),
  .low_volt_wake_o(low_volt_wake_o), .brownout_reset_o(brownout_reset_o), .irq_o(irq_o)
);

// [test/smb_top_test.sv]
// self-checking bench of the supply monitor block
`timescale 1ns/1ns
module smb_top_test
  import smb_pkg::*;
;
  typedef struct packed {logic w; logic r; logic [11:0] a; logic [31:0] d;} smb_row_t;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic [SMB_ADDR_W-1:0] addr_i = '0;
  logic [SMB_DATA_W-1:0] wdata_i = '0, exp_rd = '0, exp_d = '0, rdata_o;
  logic lvd_below_i = 1'b0, bod_below_i = 1'b0, core_supply_off_i = 1'b0;
  logic low_volt_event_o, low_volt_irq_o, low_volt_wake_o, brownout_reset_o, irq_o;
  smb_analog_t analog_o;
  int bad_count = 0, samples_checked = 0;
  smb_row_t rows[$];

  smb_top dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .lvd_below_i(lvd_below_i), .bod_below_i(bod_below_i),
    .core_supply_off_i(core_supply_off_i), .analog_o(analog_o), .low_volt_event_o(low_volt_event_o),
    .low_volt_irq_o(low_volt_irq_o), .low_volt_wake_o(low_volt_wake_o), .brownout_reset_o(brownout_reset_o),
    .irq_o(irq_o));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // one bus cycle; for a read, d is the expected data
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    exp_rd <= d;
    @(posedge sys_clk_i);
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 12'h000, 32'h0);
  endtask : idle

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    rd_d <= rd_i;
    exp_d <= exp_rd;
  end
  always @(negedge sys_clk_i) begin
    if (rd_d) begin
      chk("rdata_o", exp_d, rdata_o);
    end
  end

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rows.push_back(smb_row_t'{1'b0, 1'b1, SMB_OFS_BACKUP_LAST, 32'h0});
    for (int i = 0; i < 20; i++)
      rows.push_back(smb_row_t'{i < 10, i >= 10, 12'(SMB_OFS_BACKUP_FIRST + 4 * (i % 10)), {24'hA5C3E1, 8'(i % 10)}});
    rows.push_back(smb_row_t'{1'b1, 1'b0, SMB_OFS_BACKUP_FIRST, 32'h1234_5678});
    rows.push_back(smb_row_t'{1'b0, 1'b1, SMB_OFS_BACKUP_FIRST, 32'h1234_5678});
    rows.push_back(smb_row_t'{1'b1, 1'b0, 12'h228, 32'hFFFF_FFFF});
    rows.push_back(smb_row_t'{1'b0, 1'b1, 12'h228, 32'h0});
    rows.push_back(smb_row_t'{1'b0, 1'b1, 12'h202, 32'h0});
    rows.push_back(smb_row_t'{1'b1, 1'b0, SMB_OFS_MON_CSR, 32'hFFFF_FFFF});
    rows.push_back(smb_row_t'{1'b0, 1'b0, 12'h000, 32'h0});
    rows.push_back(smb_row_t'{1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h0077_0003});
    rows.push_back(smb_row_t'{1'b0, 1'b1, SMB_OFS_DOMAIN_CTRL, 32'h0});
    foreach (rows[k]) op(rows[k].w, rows[k].r, rows[k].a, rows[k].d);
    $display("table done");
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h0021_0000);
    lvd_below_i <= 1'b1;
    idle(4);
    #1;
    chk("low_volt_event_o", 32'h1, low_volt_event_o);
    chk("low_volt_wake_o", 32'h1, low_volt_wake_o);
    @(posedge sys_clk_i);
    #1;
    chk("low_volt_event_o", 32'h0, low_volt_event_o);
    @(posedge sys_clk_i);
    op(1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h0029_0000);
    op(1'b0, 1'b1, SMB_OFS_IRQ_STATUS, 32'h1);
    op(1'b1, 1'b0, SMB_OFS_IRQ_MASK, 32'h1);
    idle(1);
    #1;
    chk("irq_o", 32'h1, irq_o);
    @(posedge sys_clk_i);
    op(1'b1, 1'b0, SMB_OFS_IRQ_STATUS, 32'h1);
    idle(1);
    #1;
    chk("irq_o", 32'h0, irq_o);
    @(posedge sys_clk_i);
    // new rise with both wake enables: interrupt, no event
    lvd_below_i <= 1'b0;
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h0031_0000);
    idle(3);
    lvd_below_i <= 1'b1;
    idle(4);
    #1;
    chk("low_volt_event_o", 32'h0, low_volt_event_o);
    chk("low_volt_irq_o", 32'h1, low_volt_irq_o);
    @(posedge sys_clk_i);
    op(1'b1, 1'b0, SMB_OFS_IRQ_STATUS, 32'h1);
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h0);
    idle(3);
    op(1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h0);
    lvd_below_i <= 1'b0;
    $display("low-volt done");
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h1);
    bod_below_i <= 1'b1;
    idle(5);
    op(1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h9);
    idle(1);
    #1;
    chk("brownout_reset_o", 32'h1, brownout_reset_o);
    @(posedge sys_clk_i);
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h3);
    idle(2);
    #1;
    chk("brownout_reset_o", 32'h0, brownout_reset_o);
    @(posedge sys_clk_i);
    bod_below_i <= 1'b0;
    idle(4);
    op(1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h3);
    op(1'b1, 1'b0, SMB_OFS_IRQ_MASK, 32'h2);
    bod_below_i <= 1'b1;
    idle(5);
    op(1'b0, 1'b1, SMB_OFS_IRQ_STATUS, 32'h2);
    idle(1);
    #1;
    chk("irq_o", 32'h1, irq_o);
    @(posedge sys_clk_i);
    op(1'b1, 1'b0, SMB_OFS_MON_CSR, 32'h2);
    idle(3);
    op(1'b0, 1'b1, SMB_OFS_MON_CSR, 32'h2);
    bod_below_i <= 1'b0;
    $display("brown-out done");
    op(1'b1, 1'b0, 12'h20C, 32'hC0DE_0003);
    core_supply_off_i <= 1'b1;
    idle(4);
    op(1'b0, 1'b1, 12'h20C, 32'h0);
    op(1'b1, 1'b0, 12'h20C, 32'hFFFF_FFFF);
    core_supply_off_i <= 1'b0;
    idle(4);
    op(1'b0, 1'b1, 12'h20C, 32'hC0DE_0003);
    op(1'b1, 1'b0, SMB_OFS_DOMAIN_CTRL, 32'h1);
    op(1'b0, 1'b1, 12'h20C, 32'h0);
    op(1'b0, 1'b1, SMB_OFS_IRQ_MASK, 32'h0);
    idle(1);
    $display("retention done");
    // mid-run domain reset clears a stored word
    op(1'b1, 1'b0, 12'h210, 32'h5A5A_0001);
    op(1'b0, 1'b1, 12'h210, 32'h5A5A_0001);
    idle(1);
    sys_rst_i <= 1'b1;
    idle(2);
    sys_rst_i <= 1'b0;
    op(1'b0, 1'b1, 12'h210, 32'h0);
    idle(1);
    $display("reset done");
    give_verdict();
  end
endmodule : smb_top_test
